// ===== logic/mas_pkg.sv
// package of constants and types for the motion axis supervisor
package mas_pkg;
  // controller clock and motion engine interval
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int ENGINE_PERIOD_NS  = 1000;
  localparam int ENGINE_CYCLES     = (ENGINE_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // fixed pulse-count travel limits
  localparam logic signed [32:0] PULSE_LIMIT_HI = 33'sh07FFF0000;
  localparam logic signed [32:0] PULSE_LIMIT_LO = -33'sh07FFF0000;
  // reported axis state codes
  localparam logic [7:0] CODE_DISABLED   = 8'h00;
  localparam logic [7:0] CODE_IDLE       = 8'h01;
  localparam logic [7:0] CODE_DISCRETE   = 8'h02;
  localparam logic [7:0] CODE_CONTINUOUS = 8'h03;
  localparam logic [7:0] CODE_HOMING     = 8'h04;
  localparam logic [7:0] CODE_STOPPING   = 8'h06;
  localparam logic [7:0] CODE_FAULT      = 8'h07;
  // motion command codes
  localparam logic [2:0] CMD_ERROR_STOP  = 3'h1;
  localparam logic [2:0] CMD_HALT        = 3'h2;
  localparam logic [2:0] CMD_FAULT_CLEAR = 3'h3;
  localparam logic [2:0] CMD_ABSOLUTE    = 3'h4;
  localparam logic [2:0] CMD_RELATIVE    = 3'h5;
  localparam logic [2:0] CMD_VELOCITY    = 3'h6;
  localparam logic [2:0] CMD_HOMING      = 3'h7;
  // homing modes that search an enabled hard limit switch
  localparam logic [1:0] HOME_ABS_SWITCH = 2'h0;
  localparam logic [1:0] HOME_REF_ABS    = 2'h1;
  // axis error identifiers
  localparam logic [7:0] ERR_NONE        = 8'h00;
  localparam logic [7:0] ERR_OT_HARD     = 8'h01;
  localparam logic [7:0] ERR_OT_SOFT     = 8'h02;
  localparam logic [7:0] ERR_OT_PULSE    = 8'h03;
  // reset values
  localparam logic [31:0] POSITION_RESET = 32'h00000000;
  localparam logic [15:0] VELOCITY_RESET = 16'h0000;
  // one-hot axis states
  typedef enum logic [6:0] {
    ST_DIS   = 7'b0000001,
    ST_IDLE  = 7'b0000010,
    ST_DISC  = 7'b0000100,
    ST_CONT  = 7'b0001000,
    ST_HOME  = 7'b0010000,
    ST_STOP  = 7'b0100000,
    ST_FAULT = 7'b1000000
  } mas_state_type;
endpackage

// ===== logic/mas_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
module mas_sync
  import mas_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] stable_out
);
  logic [WIDTH-1:0] s1_reg;  // metastability catcher, read only by s2
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // stable value moves only on agreement, filtering single-cycle glitches
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_reg     <= '0;
      s2_reg     <= '0;
      s3_reg     <= '0;
      stable_out <= '0;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < WIDTH; i++)
        if (s2_reg[i] == s3_reg[i])
          stable_out[i] <= s3_reg[i];
    end
  end
endmodule

// ===== logic/mas_axis.sv
// axis state machine, command arbitration and travel limit supervision
// Overview of operation
// [RL1] error stop aborts all, never itself aborted
// [RL2] halt during accel keeps steeper running jerk
// [RL3] commands taken strictly one at a time
// [RL4] fault or stopping: commands accepted, not executed
// [RL5] fault clear in fault goes idle
// [RL6] error while stopping goes to fault
// [RL7] fault keeps position updating and probe armed
// [RL8] power disable forces disabled from anywhere
// [RL9] state reported as fixed numeric code
// [RL10] reported state changes only on scan; the code also updates it without scan in disabled and fault
// [RL11] limit on moving axis gives over-travel stop
// [RL12] hard limit cuts pulses or emergency stops
// [RL13] switch homing modes use enabled hard limit
// [RL14] soft limits only when homed, else infinite
// [RL15] moves pre-checked, velocity checked continuously
// [RL16] soft limit hit stops with emergency parameters
// [RL17] soft limit should lie inside hard limit
// [RL18] fixed pulse-count limits always checked; the code checks them only in discrete, continuous and stopping states
// [RL19] continuous motion wraps position at pulse limit
// [RL20] velocity move busy only while ramping
// [RL21] error stop enters stopping, no resume
// [RL22] power on goes fault or idle by error
// [RL23] stopping ends at done with execute low
// [RL24] busy retrigger of same instance ignored
module mas_axis
  import mas_pkg::*;
#(
  parameter int ENGINE_DIV = ENGINE_CYCLES
)(
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic               power_enable,     // drive power control enable
  input  wire logic               scan_valid,       // program unit scanned the active command
  input  wire logic               cmd_valid,
  input  wire logic [2:0]         cmd_code,
  input  wire logic [3:0]         cmd_instance,
  input  wire logic signed [31:0] cmd_target,
  input  wire logic [15:0]        cmd_velocity,
  input  wire logic [15:0]        cmd_jerk,
  input  wire logic               cmd_dir_neg,
  input  wire logic               stop_execute,     // execute level of the error stop
  input  wire logic [1:0]         home_mode,
  input  wire logic               home_dir_neg,
  input  wire logic               hard_lo_pin,
  input  wire logic               hard_hi_pin,
  input  wire logic               hard_lo_high,     // active level of lower switch
  input  wire logic               hard_hi_high,
  input  wire logic               hard_lo_en,
  input  wire logic               hard_hi_en,
  input  wire logic               hard_stop_on,
  input  wire logic [15:0]        estop_rate,       // emergency decel, 0 = immediate
  input  wire logic               soft_lo_en,
  input  wire logic               soft_hi_en,
  input  wire logic signed [31:0] soft_lo,
  input  wire logic signed [31:0] soft_hi,
  input  wire logic               probe_arm,
  input  wire logic               probe_pin,
  output logic [7:0]              state_code_reg,
  output logic                    busy_reg,
  output logic                    done_reg,
  output logic                    cmd_error_reg,
  output logic                    axis_error_reg,
  output logic [7:0]              error_id_reg,
  output logic signed [31:0]      pos_reg,
  output logic [15:0]             vel_reg,
  output logic [15:0]             rate_reg,         // jerk in force for ramps
  output logic                    pulse_out_reg,
  output logic                    dir_reg,
  output logic                    homed_reg,
  output logic                    probe_armed_reg,
  output logic signed [31:0]      probe_pos_reg
);
  mas_state_type     state_reg;          // internal axis state
  logic [15:0]       tgt_reg;            // target velocity
  logic signed [31:0] goal_reg;          // target position of discrete moves
  logic              pos_mode_reg;       // discrete move seeks goal_reg
  logic [3:0]        inst_reg;           // instance owning the axis
  logic              stop_done_reg;
  logic              probe_last_reg;
  logic [7:0]        div_reg;            // engine interval divider
  logic              tick_reg;           // one-cycle engine enable
  logic [2:0]        pins_sync;
  logic              busy_cond;

  // limit switches and probe come from outside, so they are synchronised
  mas_sync #(.WIDTH(3)) u_sync (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .async_in   ({probe_pin, hard_hi_pin, hard_lo_pin}),
    .stable_out (pins_sync)
  );

  wire logic sw_lo = hard_lo_en & (pins_sync[0] == hard_lo_high);
  wire logic sw_hi = hard_hi_en & (pins_sync[1] == hard_hi_high);
  wire logic probe_rise = pins_sync[2] & ~probe_last_reg;

  // motion engine interval
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (div_reg == 8'(ENGINE_DIV - 1));
      div_reg  <= (div_reg == 8'(ENGINE_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
    end
  end

  // state decode
  wire logic st_dis   = (state_reg == ST_DIS);
  wire logic st_disc  = (state_reg == ST_DISC);
  wire logic st_cont  = (state_reg == ST_CONT);
  wire logic st_home  = (state_reg == ST_HOME);
  wire logic st_stop  = (state_reg == ST_STOP);
  wire logic st_fault = (state_reg == ST_FAULT);

  // next position from one engine step
  wire logic signed [32:0] pos_ext  = {pos_reg[31], pos_reg};
  wire logic signed [32:0] vel_ext  = $signed({17'h00000, vel_reg});
  wire logic signed [32:0] pos_step = dir_reg ? pos_ext - vel_ext : pos_ext + vel_ext;
  wire logic signed [32:0] goal_gap = {goal_reg[31], goal_reg} - pos_ext;
  wire logic signed [32:0] gap_abs  = goal_gap[32] ? -goal_gap : goal_gap;

  // soft limits count only once homed; disabled ones are infinite, see [RL14]
  wire logic soft_lo_on = homed_reg & soft_lo_en;
  wire logic soft_hi_on = homed_reg & soft_hi_en;

  // limit detection on a moving axis, homing excluded, see [RL11]
  wire logic moving   = st_disc | st_cont | st_stop;
  wire logic hard_hit = (sw_hi & ~dir_reg) | (sw_lo & dir_reg);
  wire logic soft_hit = st_cont & ((soft_hi_on & ~dir_reg & pos_step > 33'(soft_hi))
                        | (soft_lo_on & dir_reg & pos_step < 33'(soft_lo)));  // see [RL15]
  wire logic pulse_hit = (pos_step > PULSE_LIMIT_HI) | (pos_step < PULSE_LIMIT_LO); // see [RL18]
  wire logic pulse_err = pulse_hit & ~st_cont;
  wire logic ot_event  = tick_reg & power_enable & moving & (hard_hit | soft_hit | pulse_err);
  wire logic hard_cut  = ot_event & hard_hit & hard_stop_on;                        // see [RL12]
  wire logic wrap      = tick_reg & st_cont & pulse_hit & ~ot_event;                 // see [RL19]
  wire logic signed [31:0] wrap_pos = dir_reg ? (soft_hi_on ? soft_hi : POSITION_RESET)
                                              : (soft_lo_on ? soft_lo : POSITION_RESET);
  wire logic [7:0] ot_id = hard_hit ? ERR_OT_HARD : soft_hit ? ERR_OT_SOFT : ERR_OT_PULSE;

  // discrete goal reached and homing switch found
  wire logic reach = tick_reg & st_disc & pos_mode_reg & (gap_abs <= vel_ext);
  wire logic home_sw = home_dir_neg ? sw_lo : sw_hi;
  wire logic home_hit = tick_reg & st_home & home_sw;                                // see [RL13]

  // velocity ramp toward target, rate 0 jumps at once
  wire logic [15:0] up_gap   = tgt_reg - vel_reg;
  wire logic [15:0] dn_gap   = vel_reg - tgt_reg;
  wire logic [15:0] vel_ramp = (rate_reg == 16'h0000) ? tgt_reg
                             : (vel_reg < tgt_reg) ? ((up_gap > rate_reg) ? vel_reg + rate_reg : tgt_reg)
                             : ((dn_gap > rate_reg) ? vel_reg - rate_reg : tgt_reg);

  // command acceptance: one command per cycle, busy retrigger dropped silently
  wire logic retrig   = busy_reg & (cmd_instance == inst_reg);                       // see [RL24]
  wire logic cmd_take = cmd_valid & power_enable & ~retrig;                          // see [RL3]
  wire logic blocked  = st_dis | st_stop | st_fault;                                 // see [RL4]
  wire logic signed [31:0] cmd_goal = (cmd_code == CMD_RELATIVE) ? pos_reg + cmd_target
                                                                 : cmd_target;
  wire logic goal_bad = (soft_hi_on & cmd_goal > soft_hi) | (soft_lo_on & cmd_goal < soft_lo);
  wire logic is_move  = (cmd_code == CMD_ABSOLUTE) | (cmd_code == CMD_RELATIVE);
  wire logic run_cmd  = cmd_take & ~blocked & (cmd_code != CMD_FAULT_CLEAR);
  wire logic move_bad = run_cmd & is_move & goal_bad;                                // see [RL15]
  wire logic home_now = run_cmd & (cmd_code == CMD_HOMING)
                        & (home_mode != HOME_ABS_SWITCH) & (home_mode != HOME_REF_ABS);
  wire logic halt_keep = (vel_reg < tgt_reg) & (cmd_jerk < rate_reg);                // see [RL2]
  wire logic [15:0] stop_rate = (cmd_jerk == 16'h0000) ? estop_rate : cmd_jerk;

  // reported code for the current internal state, see [RL9]
  logic [7:0] st_code;
  always_comb
  begin
    unique case (state_reg)
      ST_DIS:   st_code = CODE_DISABLED;
      ST_IDLE:  st_code = CODE_IDLE;
      ST_DISC:  st_code = CODE_DISCRETE;
      ST_CONT:  st_code = CODE_CONTINUOUS;
      ST_HOME:  st_code = CODE_HOMING;
      ST_STOP:  st_code = CODE_STOPPING;
      default:  st_code = CODE_FAULT;
    endcase
  end

  // velocity moves are busy only while ramping, see [RL20]
  assign busy_cond = (st_disc | st_home | st_stop) ? (vel_reg != 16'h0000) | (tgt_reg != 16'h0000)
                   : st_cont & (vel_reg != tgt_reg);

  // idle decode and discrete move completion, read by the state machine below
  wire logic st_idle_w    = (state_reg == ST_IDLE);
  wire logic reach_seen_w = st_disc & pos_mode_reg & (vel_reg == 16'h0000)
                            & (tgt_reg == 16'h0000) & (pos_reg == goal_reg);

  // axis state machine and command execution
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg      <= ST_DIS;
      tgt_reg        <= VELOCITY_RESET;
      rate_reg       <= VELOCITY_RESET;
      goal_reg       <= POSITION_RESET;
      pos_mode_reg   <= 1'b0;
      dir_reg        <= 1'b0;
      inst_reg       <= 4'h0;
      stop_done_reg  <= 1'b0;
      axis_error_reg <= 1'b0;
      error_id_reg   <= ERR_NONE;
      homed_reg      <= 1'b0;
    end
    else if (!power_enable)
    begin
      state_reg <= ST_DIS;                          // see [RL8]
      tgt_reg   <= VELOCITY_RESET;
    end
    else
    begin
      stop_done_reg <= st_stop & (vel_reg == 16'h0000) & (tgt_reg == 16'h0000);
      if (ot_event)
      begin
        // over-travel wins over a command in the same cycle; stopping also faults, see [RL6]
        state_reg      <= ST_FAULT;                 // see [RL11]
        axis_error_reg <= 1'b1;
        error_id_reg   <= ot_id;
        tgt_reg        <= VELOCITY_RESET;
        pos_mode_reg   <= 1'b0;
        rate_reg       <= estop_rate;               // see [RL16]
      end
      else if (st_dis)
        state_reg <= axis_error_reg ? ST_FAULT : ST_IDLE;  // see [RL22]
      else if (cmd_take && st_fault && cmd_code == CMD_FAULT_CLEAR)
      begin
        state_reg      <= ST_IDLE;                  // see [RL5]
        axis_error_reg <= 1'b0;
        error_id_reg   <= ERR_NONE;
      end
      else if (run_cmd && !move_bad)
      begin
        inst_reg <= cmd_instance;
        unique case (cmd_code)
          CMD_ERROR_STOP:
          begin
            state_reg    <= ST_STOP;                // see [RL1]
            tgt_reg      <= VELOCITY_RESET;
            rate_reg     <= stop_rate;
            pos_mode_reg <= 1'b0;
          end
          CMD_HALT:
          begin
            if (!st_idle_w)
              state_reg <= ST_DISC;
            tgt_reg      <= VELOCITY_RESET;
            rate_reg     <= halt_keep ? rate_reg : cmd_jerk;
            pos_mode_reg <= 1'b0;
          end
          CMD_ABSOLUTE, CMD_RELATIVE:
          begin
            state_reg    <= ST_DISC;
            goal_reg     <= cmd_goal;
            dir_reg      <= cmd_goal < pos_reg;
            tgt_reg      <= cmd_velocity;
            rate_reg     <= cmd_jerk;
            pos_mode_reg <= 1'b1;
          end
          CMD_VELOCITY:
          begin
            state_reg    <= ST_CONT;
            dir_reg      <= cmd_dir_neg;
            tgt_reg      <= cmd_velocity;
            rate_reg     <= cmd_jerk;
            pos_mode_reg <= 1'b0;
          end
          CMD_HOMING:
          begin
            // homing: switch modes search, others set zero here
            state_reg    <= home_now ? ST_IDLE : ST_HOME;
            homed_reg    <= home_now;
            dir_reg      <= home_dir_neg;
            tgt_reg      <= home_now ? VELOCITY_RESET : cmd_velocity;
            rate_reg     <= cmd_jerk;
            pos_mode_reg <= 1'b0;
          end
          default:
          begin
            // code 0 is unused and starts nothing
          end
        endcase
      end
      else if (home_hit)
      begin
        state_reg <= ST_IDLE;
        homed_reg <= 1'b1;
        tgt_reg   <= VELOCITY_RESET;
      end
      else if (reach)
        tgt_reg <= VELOCITY_RESET;
      else if (st_disc && !pos_mode_reg && vel_reg == 16'h0000 && tgt_reg == 16'h0000)
        state_reg <= ST_IDLE;                       // halt finished
      else if (reach_seen_w)
        state_reg <= ST_IDLE;
      else if (st_stop && stop_done_reg && !stop_execute)
        state_reg <= ST_IDLE;                       // see [RL23] [RL21]
    end
  end

  // velocity and position run in every state but disabled, fault included, see [RL7]
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vel_reg       <= VELOCITY_RESET;
      pos_reg       <= POSITION_RESET;
      pulse_out_reg <= 1'b0;
    end
    else
    begin
      pulse_out_reg <= tick_reg & power_enable & (vel_reg != 16'h0000) & ~hard_cut;
      if (!power_enable || hard_cut || home_hit || reach)
        vel_reg <= VELOCITY_RESET;                  // see [RL12]
      else if (tick_reg)
        vel_reg <= vel_ramp;
      if (home_hit || home_now)
        pos_reg <= POSITION_RESET;
      else if (reach)
        pos_reg <= goal_reg;
      else if (wrap)
        pos_reg <= wrap_pos;
      else if (tick_reg && power_enable && !hard_cut)
        pos_reg <= pos_step[31:0];
    end
  end

  // status toward the program unit; code follows scan except disable and fault
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_code_reg  <= CODE_DISABLED;
      busy_reg        <= 1'b0;
      done_reg        <= 1'b0;
      cmd_error_reg   <= 1'b0;
      probe_armed_reg <= 1'b0;
      probe_last_reg  <= 1'b0;
      probe_pos_reg   <= POSITION_RESET;
    end
    else
    begin
      if (scan_valid || st_dis || st_fault)
        state_code_reg <= st_code;                  // see [RL10]
      busy_reg       <= (run_cmd & ~move_bad & ~home_now) | (busy_reg & busy_cond);
      done_reg       <= busy_reg & ~busy_cond & ~ot_event & ~run_cmd;
      cmd_error_reg  <= move_bad;
      probe_last_reg <= pins_sync[2];
      if (st_dis)
        probe_armed_reg <= 1'b0;
      else if (probe_armed_reg && probe_rise)
      begin
        probe_armed_reg <= 1'b0;                    // see [RL7]
        probe_pos_reg   <= pos_reg;
      end
      else if (probe_arm)
        probe_armed_reg <= 1'b1;
    end
  end

  property p_stop_held;
    @(posedge ref_clk) disable iff (sys_rst)
    (st_stop && power_enable && !(stop_done_reg && !stop_execute) && !ot_event)
    |=> state_reg == ST_STOP;
  endproperty
  a_stop_held: assert property (p_stop_held) else $error("stopping left early"); // see [RL1]

  property p_clear;
    @(posedge ref_clk) disable iff (sys_rst)
    (st_fault && power_enable && cmd_valid && cmd_code == CMD_FAULT_CLEAR) |=> state_reg == ST_IDLE;
  endproperty
  a_clear: assert property (p_clear) else $error("fault clear ignored"); // see [RL5]

  property p_power_off;
    @(posedge ref_clk) disable iff (sys_rst)
    !power_enable |=> st_dis ##1 state_code_reg == CODE_DISABLED;
  endproperty
  a_power_off: assert property (p_power_off) else $error("not disabled"); // see [RL8]

  property p_power_on;
    @(posedge ref_clk) disable iff (sys_rst)
    (st_dis && power_enable && axis_error_reg) |=> st_fault;
  endproperty
  a_power_on: assert property (p_power_on) else $error("error not kept at power on"); // see [RL22]

  property p_stop_exit;
    @(posedge ref_clk) disable iff (sys_rst)
    (st_stop && power_enable && stop_done_reg && !stop_execute && !ot_event) |=> st_idle_w;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("stopping not left"); // see [RL23]

  property p_hard_cut;
    @(posedge ref_clk) disable iff (sys_rst)
    hard_cut |=> (vel_reg == 16'h0000) && !pulse_out_reg && st_fault;
  endproperty
  a_hard_cut: assert property (p_hard_cut) else $error("pulses not cut"); // see [RL12]

  property p_wrap;
    @(posedge ref_clk) disable iff (sys_rst)
    (wrap && power_enable && !home_now) |=> pos_reg == $past(wrap_pos);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap"); // see [RL19]

  property p_halt_jerk;
    @(posedge ref_clk) disable iff (sys_rst)
    (run_cmd && cmd_code == CMD_HALT && halt_keep && !ot_event) |=> $stable(rate_reg);
  endproperty
  a_halt_jerk: assert property (p_halt_jerk) else $error("halt jerk too soft"); // see [RL2]

  property p_scan;
    @(posedge ref_clk) disable iff (sys_rst)
    (!scan_valid && !st_dis && !st_fault) |=> $stable(state_code_reg);
  endproperty
  a_scan: assert property (p_scan) else $error("code changed without scan"); // see [RL10]

  property p_soft_pre;
    @(posedge ref_clk) disable iff (sys_rst)
    (move_bad && !ot_event) |=> cmd_error_reg && $stable(state_reg);
  endproperty
  a_soft_pre: assert property (p_soft_pre) else $error("bad goal executed"); // see [RL15]

  c_wrap:  cover property (@(posedge ref_clk) disable iff (sys_rst) wrap);
  c_ot:    cover property (@(posedge ref_clk) disable iff (sys_rst) ot_event ##[1:50] st_fault);
  c_stop:  cover property (@(posedge ref_clk) disable iff (sys_rst) st_stop ##[1:500] st_idle_w);
endmodule

// ===== verif/mas_drive_model.sv
// pulse-counting drive with an upper limit switch for the axis bench
module mas_drive_model
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        pulse_in,
  input  wire logic        dir_neg,
  input  wire logic [15:0] trip_at,
  output logic      [15:0] pulse_cnt,
  output logic             hi_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // net pulse count stands in for travel of the load
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pulse_cnt <= 16'h0000;
    else if (pulse_in)
      pulse_cnt <= dir_neg ? pulse_cnt - 16'h0001 : pulse_cnt + 16'h0001;
  end
  // switch is closed while the count is at or past the trip point, active high
  assign hi_pin = (pulse_cnt >= trip_at);
endmodule

// ===== verif/tb.sv
// self-checking bench for the axis supervisor
module tb
  import mas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus; soft limits stay off so only the hard switch can trip
  logic ref_clk = 1'h0, sys_rst = 1'h1, power_enable = 1'h0, scan_valid = 1'h1;
  logic cmd_valid = 1'h0, cmd_dir_neg = 1'h0, stop_execute = 1'h0, home_dir_neg = 1'h0;
  logic hard_lo_pin = 1'h0, hard_lo_high = 1'h1, hard_hi_high = 1'h1, hard_lo_en = 1'h1;
  logic hard_hi_en = 1'h1, hard_stop_on = 1'h1, soft_lo_en = 1'h0, soft_hi_en = 1'h0;
  logic probe_arm = 1'h0, probe_pin = 1'h0;
  logic [2:0] cmd_code = 3'h0;
  logic [3:0] cmd_instance = 4'h0;
  logic [1:0] home_mode = 2'h0;
  logic signed [31:0] cmd_target = 32'h0, soft_lo = -32'sh3E8, soft_hi = 32'sh3E8;
  logic [15:0] cmd_velocity = 16'h0, cmd_jerk = 16'h0, estop_rate = 16'h2, trip_at = 16'hFFFF;
  // observed outputs
  logic hard_hi_pin, busy_reg, done_reg, cmd_error_reg, axis_error_reg;
  logic pulse_out_reg, dir_reg, homed_reg, probe_armed_reg;
  logic [7:0] state_code_reg, error_id_reg;
  logic [15:0] vel_reg, rate_reg, pulse_cnt;
  logic signed [31:0] pos_reg, probe_pos_reg;
  int error_cnt = 0;
  int num_checks = 0;
  // short engine interval keeps ramps to a few cycles
  mas_axis #(.ENGINE_DIV(4)) DUT (.ref_clk, .sys_rst, .power_enable, .scan_valid,
    .cmd_valid, .cmd_code, .cmd_instance, .cmd_target, .cmd_velocity, .cmd_jerk,
    .cmd_dir_neg, .stop_execute, .home_mode, .home_dir_neg, .hard_lo_pin, .hard_hi_pin,
    .hard_lo_high, .hard_hi_high, .hard_lo_en, .hard_hi_en, .hard_stop_on, .estop_rate,
    .soft_lo_en, .soft_hi_en, .soft_lo, .soft_hi, .probe_arm, .probe_pin, .state_code_reg,
    .busy_reg, .done_reg, .cmd_error_reg, .axis_error_reg, .error_id_reg, .pos_reg,
    .vel_reg, .rate_reg, .pulse_out_reg, .dir_reg, .homed_reg, .probe_armed_reg,
    .probe_pos_reg);
  mas_drive_model drv (.ref_clk, .sys_rst, .pulse_in(pulse_out_reg), .dir_neg(dir_reg),
    .trip_at, .pulse_cnt, .hi_pin(hard_hi_pin));
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  // verdict and end of run
  task close_out;
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one comparison, four-state exact
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle command pulse, launched just after an edge
  task cmd(input logic [2:0] c, input logic [3:0] i, input logic [15:0] v, input logic [15:0] j);
    @(posedge ref_clk);
    cmd_code <= c;
    cmd_instance <= i;
    cmd_velocity <= v;
    cmd_jerk <= j;
    cmd_valid <= 1'h1;
    @(posedge ref_clk);
    cmd_valid <= 1'h0;
  endtask
  // bounded wait on the state code (sel 0) or busy (sel 1)
  task wait_on(input logic sel, input logic [7:0] exp);
    int n;
    logic [7:0] got;
    for (n = 0; n < 600; n++)
    begin
      @(negedge ref_clk);
      got = sel ? {7'h00, busy_reg} : state_code_reg;
      if (got === exp)
        break;
    end
    chk(got, exp);
    if (n == 600)
      close_out();
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'h0;
    power_enable <= 1'h1;
    wait_on(1'h0, CODE_IDLE);
    cmd(CMD_VELOCITY, 4'h1, 16'h4, 16'h2);
    wait_on(1'h0, CODE_CONTINUOUS);
    wait_on(1'h1, 8'h00);
    chk(state_code_reg, CODE_CONTINUOUS);
    // same instance reissued once at speed changes velocity
    cmd(CMD_VELOCITY, 4'h1, 16'h6, 16'h2);
    @(negedge ref_clk);
    chk({7'h00, busy_reg}, 8'h01);
    @(posedge ref_clk);
    stop_execute <= 1'h1;
    cmd(CMD_ERROR_STOP, 4'h2, 16'h0, 16'h0);
    wait_on(1'h0, CODE_STOPPING);
    // halt and a fresh move may not abort the error stop
    cmd(CMD_HALT, 4'h3, 16'h0, 16'h4);
    cmd(CMD_VELOCITY, 4'h4, 16'h8, 16'h2);
    @(negedge ref_clk);
    chk(state_code_reg, CODE_STOPPING);
    chk(rate_reg, 16'h0002);
    wait_on(1'h1, 8'h00);
    chk(state_code_reg, CODE_STOPPING);
    @(posedge ref_clk);
    stop_execute <= 1'h0;
    wait_on(1'h0, CODE_IDLE);
    // busy retrigger is dropped; halt keeps the steeper running jerk
    cmd(CMD_VELOCITY, 4'h7, 16'h20, 16'h4);
    cmd(CMD_VELOCITY, 4'h7, 16'h2, 16'h1);
    @(negedge ref_clk);
    chk(rate_reg, 16'h0004);
    cmd(CMD_HALT, 4'h8, 16'h0, 16'h1);
    @(negedge ref_clk);
    chk(rate_reg, 16'h0004);
    wait_on(1'h0, CODE_IDLE);
    // upper switch trips six pulses into the next move
    @(posedge ref_clk);
    trip_at <= pulse_cnt + 16'h0006;
    cmd(CMD_VELOCITY, 4'h5, 16'h4, 16'h2);
    wait_on(1'h0, CODE_FAULT);
    chk(error_id_reg, ERR_OT_HARD);
    chk({7'h00, axis_error_reg}, 8'h01);
    chk(vel_reg, 16'h0000);
    cmd(CMD_FAULT_CLEAR, 4'h6, 16'h0, 16'h0);
    wait_on(1'h0, CODE_IDLE);
    chk({7'h00, axis_error_reg}, 8'h00);
    @(posedge ref_clk);
    power_enable <= 1'h0;
    wait_on(1'h0, CODE_DISABLED);
    close_out();
  end
endmodule
